//--- include/dsac_pkg.sv
// Constants, types and decoding shared by the configuration bank
package dsac_pkg;

  // ****************************************************************
  // Register offsets and reset values
  // ****************************************************************
  localparam logic [7:0] OFS_DIAG_SRC   = 8'h23;
  localparam logic [7:0] OFS_SUPPLY_MON = 8'h25;
  localparam logic [7:0] OFS_AMP_GAIN   = 8'h26;
  localparam logic [7:0] OFS_AMP1_BLANK = 8'h27;
  localparam logic [7:0] OFS_AMP2_BLANK = 8'h28;

  localparam logic [7:0] RST_DIAG_SRC   = 8'h00;
  localparam logic [7:0] RST_SUPPLY_MON = 8'h14;
  localparam logic [7:0] RST_AMP_GAIN   = 8'h09;
  localparam logic [7:0] RST_AMP1_BLANK = 8'h00;
  localparam logic [7:0] RST_AMP2_BLANK = 8'h20;
  localparam logic [7:0] RD_UNMAPPED    = 8'h00;

  // Writable bits; the top two bits of the amplifier registers are read-only zero
  localparam logic [7:0] WMASK_FULL = 8'hff;
  localparam logic [7:0] WMASK_AMP  = 8'h3f;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SUP_UV_MODE_BIT  = 7;
  localparam int SUP_OV_MODE_LSB  = 5;
  localparam int SUP_OV_DG_LSB    = 3;
  localparam int SUP_OV_THR_BIT   = 2;
  localparam int PUMP_UV_MODE_BIT = 1;
  localparam int PUMP_UV_THR_BIT  = 0;
  localparam int AMP1_DIV_BIT     = 5;
  localparam int AMP1_GAIN_LSB    = 3;
  localparam int AMP2_DIV_BIT     = 2;
  localparam int AMP2_GAIN_LSB    = 0;
  localparam int BLK_TRIG_LSB     = 3;
  localparam int BLK_TIME_LSB     = 0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned DG_BASE_NS    = 1000;
  localparam int unsigned DG_BASE_CYC   = (DG_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DG_CNT_W      = 7;
  localparam logic [DG_CNT_W-1:0] DG_NONE_CYC = 7'h01;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    OV_LATCH = 2'b00,
    OV_AUTO  = 2'b01,
    OV_WARN  = 2'b10,
    OV_OFF   = 2'b11
  } dsac_ov_mode_t;

  typedef enum logic [2:0] {
    SEL_NONE   = 3'b000,
    SEL_DIAG   = 3'b001,
    SEL_SUPPLY = 3'b010,
    SEL_GAIN   = 3'b011,
    SEL_BLANK1 = 3'b100,
    SEL_BLANK2 = 3'b101
  } dsac_reg_sel_t;

  function automatic dsac_reg_sel_t dsac_decode(input logic [7:0] addr);
    dsac_reg_sel_t sel;
    sel = SEL_NONE;
    if (addr == OFS_DIAG_SRC) sel = SEL_DIAG;
    if (addr == OFS_SUPPLY_MON) sel = SEL_SUPPLY;
    if (addr == OFS_AMP_GAIN) sel = SEL_GAIN;
    if (addr == OFS_AMP1_BLANK) sel = SEL_BLANK1;
    if (addr == OFS_AMP2_BLANK) sel = SEL_BLANK2;
    return sel;
  endfunction

  // Deglitch code 0..3 doubles the base time each step
  function automatic logic [DG_CNT_W-1:0] dsac_dg_cycles(input logic [1:0] code);
    logic [DG_CNT_W-1:0] base;
    base = DG_CNT_W'(DG_BASE_CYC);
    return DG_CNT_W'(base << code);
  endfunction

endpackage

//--- logic/dsac_monitor.sv
// Deglitched voltage monitor with latched or auto-recovering fault flag
`timescale 1ns/100ps
module dsac_monitor
  import dsac_pkg::*;
#(
  parameter int unsigned CNT_W = DG_CNT_W
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic             detect,
  input  wire logic             enable,
  input  wire logic             auto_mode,
  input  wire logic [CNT_W-1:0] dg_cycles,
  input  wire logic             fault_clear,
  output logic                  fault
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             fault;
  } dsac_mon_t;

  dsac_mon_t state_ff;
  dsac_mon_t nxt_state;
  logic      qualified;

  // Condition counts as present only after it has held dg_cycles cycles
  assign qualified = enable && (state_ff.cnt == dg_cycles);

  always_comb begin
    nxt_state = state_ff;
    if (!enable || !detect) begin
      nxt_state.cnt = '0;
    end else if (state_ff.cnt < dg_cycles) begin
      nxt_state.cnt = CNT_W'(state_ff.cnt + 1'b1);
    end
    if (!enable) begin
      nxt_state.fault = 1'b0;
    end else if (auto_mode) begin
      nxt_state.fault = qualified;
    end else if (qualified) begin
      // Set wins over a clear arriving in the same cycle
      nxt_state.fault = 1'b1;
    end else if (fault_clear) begin
      nxt_state.fault = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign fault = state_ff.fault;

endmodule

//--- logic/dsac_cfg_regs.sv
// Diagnostic source, supply monitor and shunt amplifier configuration bank
`timescale 1ns/100ps
module dsac_cfg_regs
  import dsac_pkg::*;
#(
  parameter int unsigned AW  = 8,
  parameter int unsigned DW  = 8,
  parameter int unsigned NMON = 3
) (
  input  wire logic          clock,
  input  wire logic          arst_n,
  input  wire logic          reg_wr_en,
  input  wire logic          reg_rd_en,
  input  wire logic [AW-1:0] reg_addr,
  input  wire logic [DW-1:0] reg_wdata,
  output logic      [DW-1:0] reg_rdata,
  output logic               reg_rvalid,
  input  wire logic          offline_diag_global_en,
  output logic      [7:0]    diag_src_active,
  input  wire logic          supply_uv_detect,
  input  wire logic          supply_ov_detect,
  input  wire logic          pump_uv_detect,
  input  wire logic          fault_clear,
  output logic               supply_uv_fault,
  output logic               supply_ov_fault,
  output logic               supply_ov_warn,
  output logic               pump_uv_fault,
  output logic               supply_overvolt_threshold,
  output logic               pump_undervolt_threshold,
  output logic               amp1_ref_divider,
  output logic      [1:0]    amp1_gain_sel,
  output logic               amp2_ref_divider,
  output logic      [1:0]    amp2_gain_sel,
  output logic      [2:0]    amp1_blank_trigger,
  output logic      [2:0]    amp1_blank_time,
  output logic      [2:0]    amp2_blank_trigger,
  output logic      [2:0]    amp2_blank_time
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0]    diag_src;
    logic [7:0]    supply;
    logic [7:0]    gain;
    logic [7:0]    blank1;
    logic [7:0]    blank2;
    logic [DW-1:0] rdata;
    logic          rvalid;
    logic          started;
  } dsac_regs_t;

  dsac_regs_t    regs_ff;
  dsac_regs_t    nxt_regs;
  dsac_reg_sel_t sel;
  dsac_ov_mode_t ov_mode;

  logic [NMON-1:0] mon_detect;
  logic [NMON-1:0] mon_enable;
  logic [NMON-1:0] mon_auto;
  logic [NMON-1:0] mon_fault;
  logic [DG_CNT_W-1:0] mon_dg [NMON];
  logic [DG_CNT_W-1:0] ov_dg_cycles;

  assign sel = dsac_decode(8'(reg_addr));

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [DW-1:0] wd,
                                       input logic [7:0] mask);
    return (old & ~mask) | (8'(wd) & mask);
  endfunction

  // ****************************************************************
  // Register write and read
  // ****************************************************************
  always_comb begin
    nxt_regs = regs_ff;
    nxt_regs.started = 1'b1;
    nxt_regs.rvalid = reg_rd_en;
    if (reg_wr_en) begin
      unique case (sel)
        SEL_DIAG: begin
          nxt_regs.diag_src = merge(regs_ff.diag_src, reg_wdata, WMASK_FULL);
        end
        SEL_SUPPLY: begin
          nxt_regs.supply = merge(regs_ff.supply, reg_wdata, WMASK_FULL);
        end
        SEL_GAIN: begin
          nxt_regs.gain = merge(regs_ff.gain, reg_wdata, WMASK_AMP);
        end
        SEL_BLANK1: begin
          nxt_regs.blank1 = merge(regs_ff.blank1, reg_wdata, WMASK_AMP);
        end
        SEL_BLANK2: begin
          nxt_regs.blank2 = merge(regs_ff.blank2, reg_wdata, WMASK_AMP);
        end
        SEL_NONE: begin
          // Unmapped writes are dropped
        end
        default: begin
        end
      endcase
    end
    if (reg_rd_en) begin
      unique case (sel)
        SEL_DIAG:   nxt_regs.rdata = DW'(regs_ff.diag_src);
        SEL_SUPPLY: nxt_regs.rdata = DW'(regs_ff.supply);
        SEL_GAIN:   nxt_regs.rdata = DW'(regs_ff.gain & WMASK_AMP);
        SEL_BLANK1: nxt_regs.rdata = DW'(regs_ff.blank1 & WMASK_AMP);
        SEL_BLANK2: nxt_regs.rdata = DW'(regs_ff.blank2 & WMASK_AMP);
        SEL_NONE:   nxt_regs.rdata = DW'(RD_UNMAPPED);
        default:    nxt_regs.rdata = DW'(RD_UNMAPPED);
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      regs_ff <= '{diag_src: RST_DIAG_SRC,
                   supply:   RST_SUPPLY_MON,
                   gain:     RST_AMP_GAIN,
                   blank1:   RST_AMP1_BLANK,
                   blank2:   RST_AMP2_BLANK,
                   rdata:    '0,
                   rvalid:   1'b0,
                   started:  1'b0};
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  assign reg_rdata  = regs_ff.rdata;
  assign reg_rvalid = regs_ff.rvalid;

  // ****************************************************************
  // Configuration outputs
  // ****************************************************************
  // Sources are gated here so a stale enable cannot drive the bridge
  assign diag_src_active = regs_ff.diag_src & {8{offline_diag_global_en}};

  assign ov_mode = dsac_ov_mode_t'(regs_ff.supply[SUP_OV_MODE_LSB+:2]);
  assign ov_dg_cycles = dsac_dg_cycles(regs_ff.supply[SUP_OV_DG_LSB+:2]);

  assign supply_overvolt_threshold = regs_ff.supply[SUP_OV_THR_BIT];
  assign pump_undervolt_threshold  = regs_ff.supply[PUMP_UV_THR_BIT];
  assign amp1_ref_divider   = regs_ff.gain[AMP1_DIV_BIT];
  assign amp2_ref_divider   = regs_ff.gain[AMP2_DIV_BIT];
  assign amp1_gain_sel      = regs_ff.gain[AMP1_GAIN_LSB+:2];
  assign amp2_gain_sel      = regs_ff.gain[AMP2_GAIN_LSB+:2];
  assign amp1_blank_trigger = regs_ff.blank1[BLK_TRIG_LSB+:3];
  assign amp1_blank_time    = regs_ff.blank1[BLK_TIME_LSB+:3];
  assign amp2_blank_trigger = regs_ff.blank2[BLK_TRIG_LSB+:3];
  assign amp2_blank_time    = regs_ff.blank2[BLK_TIME_LSB+:3];

  // ****************************************************************
  // Voltage monitors: 0 supply UV, 1 supply OV, 2 pump UV
  // ****************************************************************
  assign mon_detect = {pump_uv_detect, supply_ov_detect, supply_uv_detect};
  assign mon_enable = {1'b1, ov_mode != OV_OFF, 1'b1};
  assign mon_auto   = {regs_ff.supply[PUMP_UV_MODE_BIT],
                       ov_mode == OV_AUTO,
                       regs_ff.supply[SUP_UV_MODE_BIT]};
  assign mon_dg[0] = DG_NONE_CYC;
  assign mon_dg[1] = ov_dg_cycles;
  assign mon_dg[2] = DG_NONE_CYC;

  generate
    for (genvar i = 0; i < NMON; i++) begin : g_mon
      dsac_monitor #(
        .CNT_W       (DG_CNT_W)
      ) u_mon (
        .clock       (clock),
        .arst_n      (arst_n),
        .detect      (mon_detect[i]),
        .enable      (mon_enable[i]),
        .auto_mode   (mon_auto[i]),
        .dg_cycles   (mon_dg[i]),
        .fault_clear (fault_clear),
        .fault       (mon_fault[i])
      );
    end
  endgenerate

  assign supply_uv_fault = mon_fault[0];
  // Warning mode reuses the latch but reports without flagging a fault
  assign supply_ov_fault = mon_fault[1] && (ov_mode != OV_WARN);
  assign supply_ov_warn  = mon_fault[1] && (ov_mode == OV_WARN);
  assign pump_uv_fault   = mon_fault[2];

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence s_wr(logic [7:0] ofs);
    reg_wr_en && reg_addr == AW'(ofs);
  endsequence

  sequence s_ov_held10;
    (supply_ov_detect && ov_mode == OV_LATCH && !fault_clear &&
     regs_ff.supply[SUP_OV_DG_LSB+:2] == 2'b00)[*5] ##1
    (supply_ov_detect && ov_mode == OV_LATCH && !fault_clear &&
     regs_ff.supply[SUP_OV_DG_LSB+:2] == 2'b00)[*5];
  endsequence

  chk_reset_vals: assert property (!regs_ff.started |->
    regs_ff.diag_src == RST_DIAG_SRC && regs_ff.supply == RST_SUPPLY_MON &&
    regs_ff.gain == RST_AMP_GAIN && regs_ff.blank1 == RST_AMP1_BLANK &&
    regs_ff.blank2 == RST_AMP2_BLANK)
    else $error("register reset value wrong");

  chk_diag_write: assert property (s_wr(OFS_DIAG_SRC) ##1 offline_diag_global_en
    |-> diag_src_active == $past(8'(reg_wdata)))
    else $error("diag source write not applied");

  chk_diag_gate: assert property (!offline_diag_global_en |->
    diag_src_active == 8'h00)
    else $error("diag source active without global enable");

  chk_gain_write: assert property (s_wr(OFS_AMP_GAIN) |=>
    amp1_gain_sel == $past(reg_wdata[4:3]) && amp2_gain_sel == $past(reg_wdata[1:0]))
    else $error("gain write not applied");

  chk_rsvd_read: assert property (reg_rd_en && (reg_addr == AW'(OFS_AMP_GAIN) ||
    reg_addr == AW'(OFS_AMP2_BLANK)) |=> reg_rvalid && reg_rdata[7:6] == 2'b00)
    else $error("read-only bits not zero");

  chk_blank_write: assert property (s_wr(OFS_AMP1_BLANK) |=>
    amp1_blank_trigger == $past(reg_wdata[5:3]) && amp1_blank_time == $past(reg_wdata[2:0]))
    else $error("blanking write not applied");

  chk_uv_latch: assert property (!mon_auto[0] && supply_uv_fault && !fault_clear
    |=> supply_uv_fault)
    else $error("latched undervoltage fault dropped");

  chk_uv_auto: assert property (mon_auto[0] && !supply_uv_detect ##1
    mon_auto[0] && !supply_uv_detect |=> !supply_uv_fault)
    else $error("auto recovery fault not cleared");

  chk_pump_clear: assert property (!mon_auto[2] && !pump_uv_detect ##1
    !mon_auto[2] && fault_clear && !pump_uv_detect |=> !pump_uv_fault)
    else $error("pump fault not cleared");

  chk_ov_off: assert property (ov_mode == OV_OFF |=>
    !supply_ov_fault && !supply_ov_warn)
    else $error("disabled overvoltage monitor reported");

  chk_ov_deglitch: assert property (!supply_ov_detect ##1
    !mon_fault[1] ##0 s_ov_held10 |-> !supply_ov_fault ##2 supply_ov_fault)
    else $error("overvoltage deglitch time wrong");

  chk_supply_write: assert property (s_wr(OFS_SUPPLY_MON) |=>
    supply_overvolt_threshold == $past(reg_wdata[SUP_OV_THR_BIT]) &&
    pump_undervolt_threshold == $past(reg_wdata[PUMP_UV_THR_BIT]))
    else $error("supply monitor write not applied");

  chk_div_write: assert property (s_wr(OFS_AMP_GAIN) |=>
    amp1_ref_divider == $past(reg_wdata[5]) && amp2_ref_divider == $past(reg_wdata[2]))
    else $error("divider write not applied");

  chk_blank2_write: assert property (s_wr(OFS_AMP2_BLANK) |=>
    amp2_blank_trigger == $past(reg_wdata[5:3]) && amp2_blank_time == $past(reg_wdata[2:0]))
    else $error("amplifier 2 blanking write not applied");

  chk_blank1_rsvd: assert property (reg_rd_en && reg_addr == AW'(OFS_AMP1_BLANK) |=>
    reg_rdata[7:6] == 2'b00)
    else $error("blanking read-only bits not zero");

  chk_pump_latch: assert property (!mon_auto[2] && pump_uv_fault && !fault_clear
    |=> pump_uv_fault)
    else $error("latched pump fault dropped");

  chk_pump_auto: assert property (mon_auto[2] && !pump_uv_detect ##1
    mon_auto[2] && !pump_uv_detect |=> !pump_uv_fault)
    else $error("pump auto recovery not cleared");

  chk_uv_set: assert property (supply_uv_detect |=> ##1 supply_uv_fault)
    else $error("supply undervoltage not flagged");

  chk_pump_set: assert property (pump_uv_detect |=> ##1 pump_uv_fault)
    else $error("pump undervoltage not flagged");

  chk_ov_auto: assert property (ov_mode == OV_AUTO && !supply_ov_detect ##1
    ov_mode == OV_AUTO && !supply_ov_detect |=> !supply_ov_fault && !supply_ov_warn)
    else $error("overvoltage auto recovery not cleared");

endmodule

//--- testbench/dsac_host_model.sv
// Host-side model that issues register reads and writes to the bank
`timescale 1ns/100ps
module dsac_host_model (
  input  wire logic       clock,
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // ****************************************
  // Bus tasks
  // ****************************************
  // Released bus shows the inverse, so a stale address never passes for a held one
  task automatic release_bus();
    reg_addr  = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clock);
    reg_wr_en = 1'b1;
    reg_addr  = addr;
    reg_wdata = data;
    @(negedge clock);
    reg_wr_en = 1'b0;
    release_bus();
  endtask

  task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    int n;
    @(negedge clock);
    reg_rd_en = 1'b1;
    reg_addr  = addr;
    @(negedge clock);
    reg_rd_en = 1'b0;
    release_bus();
    ok   = 1'b0;
    data = 8'h00;
    for (n = 0; n < 4 && !ok; n++) begin
      if (reg_rvalid === 1'b1) begin
        ok   = 1'b1;
        data = reg_rdata;
      end else begin
        @(negedge clock);
      end
    end
  endtask
endmodule

//--- testbench/dsac_cfg_regs_bench.sv
// Self-checking bench for the configuration bank
`timescale 1ns/100ps
module dsac_cfg_regs_bench
  import dsac_pkg::*;
;
  localparam logic [7:0] ADDRS [6] = '{8'h23, 8'h25, 8'h26, 8'h27, 8'h28, 8'h24};
  localparam logic [7:0] RSTS  [6] = '{8'h00, 8'h14, 8'h09, 8'h00, 8'h20, 8'h00};
  localparam logic [7:0] MASKS [6] = '{8'hff, 8'hff, 8'h3f, 8'h3f, 8'h3f, 8'h00};
  localparam logic [7:0] PATS  [3] = '{8'hff, 8'h5a, 8'ha5};

  logic       clock;
  logic       arst_n;
  logic       reg_wr_en;
  logic       reg_rd_en;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       reg_rvalid;
  logic       offline_diag_global_en;
  logic [7:0] diag_src_active;
  logic       supply_uv_detect;
  logic       supply_ov_detect;
  logic       pump_uv_detect;
  logic       fault_clear;
  logic       supply_uv_fault;
  logic       supply_ov_fault;
  logic       supply_ov_warn;
  logic       pump_uv_fault;
  logic       supply_overvolt_threshold;
  logic       pump_undervolt_threshold;
  logic       amp1_ref_divider;
  logic [1:0] amp1_gain_sel;
  logic       amp2_ref_divider;
  logic [1:0] amp2_gain_sel;
  logic [2:0] amp1_blank_trigger;
  logic [2:0] amp1_blank_time;
  logic [2:0] amp2_blank_trigger;
  logic [2:0] amp2_blank_time;
  logic [7:0] gain_view;
  logic [7:0] blk1_view;
  logic [7:0] blk2_view;
  int         bad_count;
  int         tests_run;
  int         i;
  int         p;

  assign gain_view = {2'b00, amp1_ref_divider, amp1_gain_sel, amp2_ref_divider, amp2_gain_sel};
  assign blk1_view = {2'b00, amp1_blank_trigger, amp1_blank_time};
  assign blk2_view = {2'b00, amp2_blank_trigger, amp2_blank_time};

  dsac_host_model u_host (.clock, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid);

  dsac_cfg_regs u_dut (.clock, .arst_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .offline_diag_global_en, .diag_src_active, .supply_uv_detect,
    .supply_ov_detect, .pump_uv_detect, .fault_clear, .supply_uv_fault, .supply_ov_fault,
    .supply_ov_warn, .pump_uv_fault, .supply_overvolt_threshold, .pump_undervolt_threshold,
    .amp1_ref_divider, .amp1_gain_sel, .amp2_ref_divider, .amp2_gain_sel, .amp1_blank_trigger,
    .amp1_blank_time, .amp2_blank_trigger, .amp2_blank_time);

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] got;
    logic       ok;
    u_host.rd(addr, got, ok);
    if (!ok) begin
      bad_count++;
      $display("wrong value at %0t: no read answer for %h", $time, addr);
      summarize();
    end else begin
      chk(got, exp);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic pulse_clear();
    @(negedge clock);
    fault_clear = 1'b1;
    @(negedge clock);
    fault_clear = 1'b0;
  endtask

  task automatic set_det(input int m, input logic v);
    case (m)
      0: supply_uv_detect = v;
      1: pump_uv_detect = v;
      default: supply_ov_detect = v;
    endcase
  endtask

  function automatic logic [7:0] flag(input int m);
    case (m)
      0: return {7'h00, supply_uv_fault};
      1: return {7'h00, pump_uv_fault};
      2: return {7'h00, supply_ov_fault};
      default: return {7'h00, supply_ov_warn};
    endcase
  endfunction

  // Short burst if hold exceeds 1, then a qualified condition, clear while held, release, clear
  task automatic mon_run(input int m, input int hold, input logic latched);
    if (hold > 1) begin
      set_det(m, 1'b1);
      ticks(hold - 1);
      set_det(m, 1'b0);
      ticks(4);
      chk(flag(m), 8'h00);
    end
    set_det(m, 1'b1);
    ticks(hold + 2);
    chk(flag(m), 8'h01);
    pulse_clear();
    chk(flag(m), 8'h01);
    set_det(m, 1'b0);
    ticks(3);
    chk(flag(m), {7'h00, latched});
    pulse_clear();
    ticks(1);
    chk(flag(m), 8'h00);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    arst_n = 1'b0;
    offline_diag_global_en = 1'b0;
    supply_uv_detect = 1'b0;
    supply_ov_detect = 1'b0;
    pump_uv_detect = 1'b0;
    fault_clear = 1'b0;
    bad_count = 0;
    tests_run = 0;
    repeat (20) @(posedge clock);
    @(negedge clock);
    arst_n = 1'b1;
    for (i = 0; i < 6; i++)
      rd_chk(ADDRS[i], RSTS[i]);
    chk(gain_view, 8'h09);
    chk(blk1_view, 8'h00);
    chk(blk2_view, 8'h20);
    chk({6'h00, supply_overvolt_threshold, pump_undervolt_threshold}, 8'h02);
    chk(diag_src_active, 8'h00);
    $display("test reset values done");

    for (p = 0; p < 3; p++) begin
      for (i = 0; i < 6; i++)
        u_host.wr(ADDRS[i], PATS[p]);
      for (i = 0; i < 6; i++)
        rd_chk(ADDRS[i], PATS[p] & MASKS[i]);
      chk(gain_view, PATS[p] & 8'h3f);
      chk(blk1_view, PATS[p] & 8'h3f);
      chk(blk2_view, PATS[p] & 8'h3f);
      chk({6'h00, supply_overvolt_threshold, pump_undervolt_threshold},
          {6'h00, PATS[p][2], PATS[p][0]});
    end
    $display("test write and read back done");

    u_host.wr(8'h23, 8'h96);
    chk(diag_src_active, 8'h00);
    offline_diag_global_en = 1'b1;
    ticks(1);
    chk(diag_src_active, 8'h96);
    u_host.wr(8'h23, 8'h69);
    chk(diag_src_active, 8'h69);
    offline_diag_global_en = 1'b0;
    ticks(1);
    chk(diag_src_active, 8'h00);
    $display("test diagnostic sources done");

    u_host.wr(8'h25, 8'h74);
    mon_run(0, 1, 1'b1);
    mon_run(1, 1, 1'b1);
    u_host.wr(8'h25, 8'hf6);
    mon_run(0, 1, 1'b0);
    mon_run(1, 1, 1'b0);
    for (i = 0; i < 4; i++) begin
      u_host.wr(8'h25, {3'b000, i[1:0], 3'b100});
      mon_run(2, 10 << i, 1'b1);
    end
    u_host.wr(8'h25, 8'h24);
    mon_run(2, 10, 1'b0);
    u_host.wr(8'h25, 8'h44);
    mon_run(3, 10, 1'b1);
    chk({7'h00, supply_ov_fault}, 8'h00);
    u_host.wr(8'h25, 8'h64);
    set_det(2, 1'b1);
    ticks(14);
    chk({6'h00, supply_ov_fault, supply_ov_warn}, 8'h00);
    set_det(2, 1'b0);
    $display("test monitors done");

    // A second reset mid-run must drop a latched flag and restore the bank
    u_host.wr(8'h25, 8'h74);
    set_det(0, 1'b1);
    ticks(3);
    chk({7'h00, supply_uv_fault}, 8'h01);
    set_det(0, 1'b0);
    arst_n = 1'b0;
    ticks(2);
    chk({7'h00, supply_uv_fault}, 8'h00);
    arst_n = 1'b1;
    rd_chk(8'h25, 8'h14);
    rd_chk(8'h23, 8'h00);
    $display("test second reset done");
    summarize();
  end
endmodule
